/* design/sich_handler.sv */
`timescale 1ns/10ps
module sich_handler import sich_pkg::*; #(
  parameter int                  DEPTH       = ERR_DEPTH,
  // factory text is arbitrary; char 0 in the low byte
  parameter logic [ID_BITS-1:0]  FACTORY_ID  = ID_BITS'("0.1,LEDOM,ECIVED"),
  parameter logic [LEN_W-1:0]    FACTORY_LEN = LEN_W'(16)
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire sich_cmd_s   cmd,
  input  wire sich_char_s  str_in,
  input  wire sich_err_s   err_in,
  output logic             cmd_ready,
  output sich_resp_s       resp,
  output logic             beep,
  output logic             beep_enable,
  output logic             id_user,
  output logic [QDE_W-1:0] qde,
  output logic [$clog2(DEPTH+1)-1:0] err_count
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [$clog2(DEPTH+1)-1:0] FULL_CNT = ($clog2(DEPTH+1))'(DEPTH);

  function automatic logic [CHAR_W-1:0] pick_char(input logic [MSG_BITS-1:0] buf_v,
                                                  input logic [LEN_W-1:0]    idx);
    pick_char = buf_v[idx*CHAR_W +: CHAR_W];
  endfunction

  sich_state_e         state;
  sich_state_e         next_state;
  logic [ID_BITS-1:0]  uid;
  logic [LEN_W-1:0]    uid_len;
  logic [CODE_W-1:0]   code_mem [DEPTH];
  logic [LEN_W-1:0]    len_mem  [DEPTH];
  logic [MSG_BITS-1:0] msg_mem  [DEPTH];
  logic [PW-1:0]       wr_ptr;
  logic [PW-1:0]       rd_ptr;
  logic [MSG_BITS-1:0] snd_buf;
  logic [LEN_W-1:0]    snd_len;
  logic [LEN_W-1:0]    snd_idx;
  logic [CODE_W-1:0]   snd_num;
  logic                snd_head;
  logic                snd_done;
  logic                accept;
  logic                push;
  logic                pop;
  logic                cls;
  logic [CODE_W-1:0]   head_code;

  assign accept    = cmd.valid && cmd_ready;
  assign push      = err_in.valid && (err_count != FULL_CNT);
  assign pop       = accept && cmd.op == OP_ERR_QUERY && err_count != '0;
  assign cls       = accept && cmd.op == OP_CLS;
  assign head_code = code_mem[rd_ptr];
  assign snd_done  = snd_head ? (snd_len == '0) : (LEN_W'(snd_idx + 1'b1) == snd_len);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept && cmd.op == OP_ID_SRC && cmd.has_str) begin
          next_state = ST_LOAD;
        end else if (accept && (cmd.op == OP_ID_QUERY || cmd.op == OP_ERR_QUERY)) begin
          next_state = ST_SEND;
        end
      end
      ST_LOAD: begin
        if (str_in.valid && str_in.last) begin
          next_state = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (snd_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      cmd_ready <= 1'b1;
    end else begin
      state     <= next_state;
      cmd_ready <= (next_state == ST_IDLE);
    end
  end

  // identity source select and user string
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      id_user <= ID_USER_RESET;
      uid     <= '0;
      uid_len <= '0;
    end else if (accept && cmd.op == OP_ID_SRC) begin
      id_user <= cmd.on;
      if (cmd.has_str) begin
        uid_len <= '0;
      end
    end else if (state == ST_LOAD && str_in.valid && uid_len < LEN_W'(ID_MAX_CHARS)) begin
      // characters past the limit are dropped rather than wrapping into the string
      uid[uid_len*CHAR_W +: CHAR_W] <= str_in.data;
      uid_len                       <= LEN_W'(uid_len + 1'b1);
    end
  end

  // beeper flag is a plain flop: power loss always brings back the reset value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      beep_enable <= BEEP_RESET;
      beep        <= 1'b0;
    end else begin
      if (accept && cmd.op == OP_BEEP_SET) begin
        beep_enable <= cmd.on;
      end
      beep <= beep_enable && err_in.valid;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      qde <= QDE_RESET;
    end else if (accept && cmd.op == OP_QDE_SET) begin
      qde <= cmd.value & QDE_USED_MASK;
    end else if (accept && cmd.op == OP_PRESET) begin
      qde <= QDE_RESET;
    end
  end

  // entry storage carries no reset; only pointers and count are control state
  always_ff @(posedge clock) begin
    if (push) begin
      code_mem[wr_ptr] <= err_in.code;
      len_mem[wr_ptr]  <= err_in.len;
      msg_mem[wr_ptr]  <= err_in.msg;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      err_count <= '0;
    end else if (cls) begin
      // an error arriving with the clear survives as the only entry, except when the queue is full
      rd_ptr    <= wr_ptr;
      wr_ptr    <= PW'(wr_ptr + push);
      err_count <= push ? ($clog2(DEPTH+1))'(1) : '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      err_count <= ($clog2(DEPTH+1))'(err_count + push - pop);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      snd_buf  <= '0;
      snd_len  <= '0;
      snd_idx  <= '0;
      snd_num  <= '0;
      snd_head <= 1'b0;
    end else if (accept && cmd.op == OP_ID_QUERY) begin
      snd_idx  <= '0;
      snd_head <= 1'b1;
      if (id_user) begin
        snd_buf <= MSG_BITS'(uid);
        snd_len <= uid_len;
        snd_num <= CODE_W'(uid_len);
      end else begin
        snd_buf <= MSG_BITS'(FACTORY_ID);
        snd_len <= FACTORY_LEN;
        snd_num <= CODE_W'(FACTORY_LEN);
      end
    end else if (accept && cmd.op == OP_ERR_QUERY) begin
      snd_idx  <= '0;
      snd_head <= 1'b1;
      if (pop) begin
        snd_buf <= msg_mem[rd_ptr];
        snd_len <= len_mem[rd_ptr];
        snd_num <= head_code;
      end else begin
        snd_buf <= MSG_BITS'(NO_ERROR_MSG);
        snd_len <= LEN_W'(NO_ERROR_LEN);
        snd_num <= NO_ERROR_CODE;
      end
    end else if (state == ST_SEND) begin
      if (snd_head) begin
        snd_head <= 1'b0;
      end else begin
        snd_idx <= LEN_W'(snd_idx + 1'b1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resp <= '0;
    end else if (state == ST_SEND) begin
      resp.valid   <= 1'b1;
      resp.is_char <= !snd_head;
      resp.last    <= snd_done;
      resp.data    <= snd_head ? snd_num : CODE_W'(pick_char(snd_buf, snd_idx));
    end else if (accept && cmd.op == OP_BEEP_QUERY) begin
      resp <= '{valid: 1'b1, is_char: 1'b0, last: 1'b1, data: CODE_W'(beep_enable)};
    end else if (accept && cmd.op == OP_QDE_QUERY) begin
      resp <= '{valid: 1'b1, is_char: 1'b0, last: 1'b1, data: qde};
    end else begin
      resp <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_qde_write;
    accept && cmd.op == OP_QDE_SET |=> qde == ($past(cmd.value) & QDE_USED_MASK);
  endproperty
  a_qde_write: assert property (p_qde_write) else $error("qde write mismatch");
  property p_qde_unused;
    (qde & ~QDE_USED_MASK) == 16'h0000;
  endproperty
  a_qde_unused: assert property (p_qde_unused) else $error("qde unused bit set");
  property p_preset;
    accept && cmd.op == OP_PRESET |=> qde == 16'h0000;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not clear qde");
  property p_qde_query;
    accept && cmd.op == OP_QDE_QUERY |=> resp.valid && resp.last && resp.data == $past(qde);
  endproperty
  a_qde_query: assert property (p_qde_query) else $error("qde query wrong");
  property p_full_drop;
    err_in.valid && err_count == FULL_CNT && !cls |=> err_count == $past(err_count) - $past(pop);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full queue grew");
  property p_pop_order;
    pop |-> ##2 (resp.valid && !resp.is_char && resp.data == $past(head_code, 2));
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("error read not oldest");
  property p_empty_read;
    accept && cmd.op == OP_ERR_QUERY && err_count == '0
      |-> ##2 (resp.valid && !resp.is_char && resp.data == NO_ERROR_CODE);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read not +0");
  property p_id_user;
    accept && cmd.op == OP_ID_QUERY && id_user |-> ##2 resp.data == CODE_W'(uid_len);
  endproperty
  a_id_user: assert property (p_id_user) else $error("user identity not sent");
  property p_id_factory;
    accept && cmd.op == OP_ID_QUERY && !id_user |-> ##2 resp.data == CODE_W'(FACTORY_LEN);
  endproperty
  a_id_factory: assert property (p_id_factory) else $error("factory identity not sent");
  property p_id_len;
    uid_len <= LEN_W'(ID_MAX_CHARS);
  endproperty
  a_id_len: assert property (p_id_len) else $error("user identity too long");
  property p_beep;
    err_in.valid && beep_enable |=> beep;
  endproperty
  a_beep: assert property (p_beep) else $error("no beep on error");
  property p_cls;
    cls && !err_in.valid |=> err_count == '0;
  endproperty
  a_cls: assert property (p_cls) else $error("clear status left errors");
  property p_cls_push;
    cls && push |=> err_count == ($clog2(DEPTH+1))'(1);
  endproperty
  a_cls_push: assert property (p_cls_push) else $error("error lost in clear");
endmodule

/* common/sich_pkg.sv */
// Operation
// - With the identity source select on, the identity query returns the stored user string.
// - With the select off, the identity query returns the factory string and ignores the user string.
// - The user identity string holds at most 35 characters, and the query returns no more than that.
// - The identity source command sets the select and, when a string is present, stores it as the user string.
// - The error query removes and returns the oldest error, so errors leave in arrival order.
// - Each error queue entry stores a message of up to 80 characters.
// - The error queue holds 16 entries; while it is full, new errors are dropped until a read frees one.
// - An error query on an empty queue returns code +0 with the no-error message and leaves the queue as it is.
// - With the error beeper flag on, each detected error sounds the beeper; the flag reads as 1 on and 0 off.
// - The error beeper flag is volatile and is lost when power is removed.
// - The questionable-data enable register is 16 bits and takes any value from 0 to 65535 as a bit pattern.
// - Only bits 0, 1, 9, 11, 12 and 13 of the questionable-data enable register have any effect.
// - A write to the questionable-data enable register replaces all of its contents.
// - A query of the questionable-data enable register returns its present contents.
// - The clear-status command empties the error queue and clears the event state; the code has no event state and only empties the queue.
// - The status preset command clears every questionable-data enable bit.
package sich_pkg;
  localparam int          CHAR_W        = 8;
  localparam int          ID_MAX_CHARS  = 35;
  localparam int          ID_BITS       = ID_MAX_CHARS * CHAR_W;
  localparam int          ERR_MSG_CHARS = 80;
  localparam int          MSG_BITS      = ERR_MSG_CHARS * CHAR_W;
  localparam int          LEN_W         = $clog2(ERR_MSG_CHARS + 1);
  localparam int          ERR_DEPTH     = 16;
  localparam int          QDE_W         = 16;
  localparam int          CODE_W        = 16;
  localparam logic [15:0] QDE_USED_MASK = 16'h3a03;
  localparam logic [15:0] QDE_RESET     = 16'h0000;
  localparam logic        BEEP_RESET    = 1'b0;
  localparam logic        ID_USER_RESET = 1'b0;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;
  localparam int          NO_ERROR_LEN  = 8;
  // char 0 sits in the low byte, so the text reads backwards here
  localparam logic [NO_ERROR_LEN*CHAR_W-1:0] NO_ERROR_MSG = "rorre oN";

  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_ID_SRC     = 4'h1,
    OP_ID_QUERY   = 4'h2,
    OP_ERR_QUERY  = 4'h3,
    OP_BEEP_SET   = 4'h4,
    OP_BEEP_QUERY = 4'h5,
    OP_QDE_SET    = 4'h6,
    OP_QDE_QUERY  = 4'h7,
    OP_CLS        = 4'h8,
    OP_PRESET     = 4'h9
  } sich_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOAD = 3'h2,
    ST_SEND = 3'h4
  } sich_state_e;

  typedef struct packed {
    logic             valid;
    sich_op_e         op;
    logic             on;
    logic             has_str;
    logic [QDE_W-1:0] value;
  } sich_cmd_s;

  typedef struct packed {
    logic              valid;
    logic              last;
    logic [CHAR_W-1:0] data;
  } sich_char_s;

  typedef struct packed {
    logic                valid;
    logic [CODE_W-1:0]   code;
    logic [LEN_W-1:0]    len;
    logic [MSG_BITS-1:0] msg;
  } sich_err_s;

  typedef struct packed {
    logic              valid;
    logic              is_char;
    logic              last;
    logic [CODE_W-1:0] data;
  } sich_resp_s;
endpackage

/* bench/sich_host_model.sv */
`timescale 1ns/10ps
module sich_host_model import sich_pkg::*; (
  input  wire logic       clock,
  input  wire logic       cmd_ready,
  input  wire sich_resp_s resp,
  output sich_cmd_s       cmd,
  output sich_char_s      str_in
);
  sich_resp_s rq[$];
  int         hang = 0;

  initial begin
    cmd = '0;
    str_in = '0;
  end

  // beats stand one cycle and cannot be held off, so every edge is sampled
  always @(posedge clock) begin
    if (resp.valid === 1'b1) begin
      rq.push_back(resp);
    end
  end

  // request held until the edge that takes it; nch > 0 sends a string of nch chars
  task automatic issue(input sich_op_e op, input logic on, input logic [QDE_W-1:0] value,
                       input int nch);
    int n;
    n = 0;
    @(posedge clock);
    cmd <= '{1'b1, op, on, nch > 0, value};
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      hang++;
    end
    cmd <= '0;
    // a count above the limit is sent only when a test asks for the overflow
    for (int i = 0; i < nch; i++) begin
      str_in <= '{1'b1, i == nch - 1, 8'(8'h41 + i)};
      @(posedge clock);
    end
    str_in <= '0;
  endtask
endmodule

/* bench/status_ident_cmd_handler_test.sv */
`timescale 1ns/10ps
module status_ident_cmd_handler_test import sich_pkg::*;;
  localparam int DEP = 4;
  logic                       clock = 1'b0;
  logic                       rst_b = 1'b0;
  sich_err_s                  err_in = '0;
  sich_cmd_s                  cmd;
  sich_char_s                 str_in;
  sich_resp_s                 resp;
  logic                       cmd_ready;
  logic                       beep;
  logic                       beep_enable;
  logic                       id_user;
  logic [QDE_W-1:0]           qde;
  logic [$clog2(DEP+1)-1:0]   err_count;
  int                         num_errors = 0;
  int                         checks = 0;
  logic [7:0]                 none[$];
  // write value in the upper half, expected contents in the lower
  logic [31:0] rows[5] = '{32'hffff_3a03, 32'hc5fc_0000, 32'h0004_0000, 32'h3800_3800,
                           32'h0203_0203};

  sich_handler #(.DEPTH(DEP), .FACTORY_ID(ID_BITS'("CBA")), .FACTORY_LEN(LEN_W'(3))) i_dut (
    .clock(clock), .rst_b(rst_b), .cmd(cmd), .str_in(str_in), .err_in(err_in),
    .cmd_ready(cmd_ready), .resp(resp), .beep(beep), .beep_enable(beep_enable),
    .id_user(id_user), .qde(qde), .err_count(err_count));
  sich_host_model i_host (.clock(clock), .cmd_ready(cmd_ready), .resp(resp), .cmd(cmd),
    .str_in(str_in));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_beat(input sich_resp_s got, input logic ch, input logic lst,
                          input logic [15:0] exp);
    checks++;
    if (got.is_char !== ch || got.last !== lst || got.data !== exp) begin
      num_errors++;
      $display("BAD t=%0t beat %b%b %h exp %b%b %h", $time, got.is_char, got.last, got.data,
               ch, lst, exp);
    end
  endtask

  task automatic expect_resp(input logic [15:0] num, input logic [7:0] ch[$]);
    int n;
    n = 0;
    while (i_host.rq.size() < ch.size() + 1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (i_host.rq.size() < ch.size() + 1) begin
      num_errors++;
      $display("BAD t=%0t answer missing", $time);
      end_of_test();
    end
    chk_beat(i_host.rq.pop_front(), 1'b0, ch.size() == 0, num);
    foreach (ch[i]) chk_beat(i_host.rq.pop_front(), 1'b1, i == ch.size() - 1, {8'h00, ch[i]});
  endtask

  task automatic done(input string name);
    if (i_host.hang != 0) begin
      num_errors++;
      $display("BAD t=%0t command never taken", $time);
      end_of_test();
    end
    $display("test %s ends", name);
  endtask

  function automatic logic [7:0] mchar(input logic [15:0] c, input int i);
    return 8'(8'h20 + c + i);
  endfunction

  task automatic inject(input logic [15:0] code, input int len, input logic eb);
    sich_err_s e;
    e = '0;
    e.valid = 1'b1;
    e.code = code;
    e.len = LEN_W'(len);
    for (int i = 0; i < len; i++) e.msg[8*i +: 8] = mchar(code, i);
    @(posedge clock);
    err_in <= e;
    @(posedge clock);
    err_in <= '0;
    #1 chk(16'(beep), 16'(eb), "beep");
    @(posedge clock);
    #1 chk(16'(beep), 16'h0000, "beep end");
  endtask

  task automatic query_err(input logic [15:0] code, input int len);
    logic [7:0] q[$];
    for (int i = 0; i < len; i++) q.push_back(mchar(code, i));
    i_host.issue(OP_ERR_QUERY, 1'b0, 16'h0000, 0);
    expect_resp(code, q);
  endtask

  task automatic pulse_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
  endtask

  initial begin
    logic [7:0] q[$];
    string      s;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1 chk(qde, QDE_RESET, "qde");
    chk({beep_enable, id_user, cmd_ready}, {BEEP_RESET, ID_USER_RESET, 1'b1}, "flags");
    chk(16'(err_count), 16'h0000, "count");
    done("reset");
    foreach (rows[i]) begin
      i_host.issue(OP_QDE_SET, 1'b0, rows[i][31:16], 0);
      #1 chk(qde, rows[i][15:0], "qde");
      i_host.issue(OP_QDE_QUERY, 1'b0, 16'h0000, 0);
      expect_resp(rows[i][15:0], none);
    end
    done("qde table");
    i_host.issue(OP_PRESET, 1'b0, 16'h0000, 0);
    #1 chk(qde, 16'h0000, "preset");
    // beeper on, then off, each with an error and a query
    for (int b = 1; b >= 0; b--) begin
      i_host.issue(OP_BEEP_SET, b[0], 16'h0000, 0);
      i_host.issue(OP_BEEP_QUERY, 1'b0, 16'h0000, 0);
      expect_resp(16'(b), none);
      inject(16'h0009, 1, b[0]);
      query_err(16'h0009, 1);
    end
    i_host.issue(OP_BEEP_SET, 1'b1, 16'h0000, 0);
    pulse_reset();
    chk(16'(beep_enable), 16'h0000, "volatile");
    done("beeper");
    inject(16'h0001, 80, 1'b0);
    inject(16'h0002, 0, 1'b0);
    inject(16'h0003, 2, 1'b0);
    inject(16'h0004, 1, 1'b0);
    inject(16'h0005, 3, 1'b0);
    chk(16'(err_count), 16'(DEP), "full");
    query_err(16'h0001, 80);
    inject(16'h0006, 1, 1'b0);
    query_err(16'h0002, 0);
    query_err(16'h0003, 2);
    query_err(16'h0004, 1);
    query_err(16'h0006, 1);
    s = "No error";
    foreach (s[i]) q.push_back(s[i]);
    i_host.issue(OP_ERR_QUERY, 1'b0, 16'h0000, 0);
    expect_resp(16'h0000, q);
    #1 chk(16'(err_count), 16'h0000, "empty");
    inject(16'h0007, 1, 1'b0);
    inject(16'h0008, 1, 1'b0);
    i_host.issue(OP_CLS, 1'b0, 16'h0000, 0);
    #1 chk(16'(err_count), 16'h0000, "cls");
    // an error arriving in the same cycle as the clear must survive it
    inject(16'h000b, 1, 1'b0);
    fork
      i_host.issue(OP_CLS, 1'b0, 16'h0000, 0);
      inject(16'h000a, 1, 1'b0);
    join
    chk(16'(err_count), 16'h0001, "cls with error");
    query_err(16'h000a, 1);
    done("error queue");
    q = {};
    for (int i = 0; i < 35; i++) q.push_back(8'(8'h41 + i));
    i_host.issue(OP_ID_SRC, 1'b1, 16'h0000, 37);
    #1 chk(16'(id_user), 16'h0001, "select");
    i_host.issue(OP_ID_QUERY, 1'b0, 16'h0000, 0);
    expect_resp(16'd35, q);
    i_host.issue(OP_ID_SRC, 1'b0, 16'h0000, 0);
    i_host.issue(OP_ID_QUERY, 1'b0, 16'h0000, 0);
    expect_resp(16'd3, '{8'h41, 8'h42, 8'h43});
    // select alone must keep the stored string
    i_host.issue(OP_ID_SRC, 1'b1, 16'h0000, 0);
    i_host.issue(OP_ID_QUERY, 1'b0, 16'h0000, 0);
    expect_resp(16'd35, q);
    chk(16'(i_host.rq.size()), 16'h0000, "stray beats");
    done("identity");
    end_of_test();
  end
endmodule
